/* File: rtl/reset_and_watchdog_control.v */
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "reset_watchdog_defs.vh"

module reset_and_watchdog_control #(
  parameter        TICK_DIV         = `SYS_CLK_HZ / `WDT_OSC_HZ,
  parameter [15:0] DELAY_BASE_TICKS = `DELAY_BASE_TICKS
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        power_low,
  input  wire        ext_reset_n,
  input  wire        reset_pin_enable,
  input  wire        brownout_low,
  input  wire [2:0]  brownout_level_fuses,
  input  wire        safety_level_fuse,
  input  wire [1:0]  startup_time_fuses,
  input  wire [3:0]  clock_select_fuses,
  input  wire        irq_ack,
  output reg         internal_reset,
  output wire        port_hold,
  output wire        wdt_irq,
  output reg         ref_enable
);

  // Divider end point, cut to the counter width on purpose
  localparam integer TICK_LAST_I = TICK_DIV - 1;
  localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];

  // Time base for the watchdog: one-cycle enable at the oscillator rate
  reg  [15:0] div_cnt;
  wire        tick = (div_cnt == TICK_LAST);

  always @(posedge clock) begin
    if (rst) begin
      div_cnt <= 16'h0000;
    end else if (tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // Two-flop synchronisers for the detector and pin inputs
  reg [2:0] sync1;
  reg [2:0] sync2;

  always @(posedge clock) begin
    if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {power_low, ~ext_reset_n, brownout_low};
      sync2 <= sync1;
    end
  end

  wire bod_enabled = (brownout_level_fuses != `BOD_OFF_CODE);
  wire por_src     = sync2[2];
  wire ext_src     = sync2[1] & reset_pin_enable;
  wire bod_src     = sync2[0] & bod_enabled;
  reg  wd_pulse;
  wire any_src     = por_src | ext_src | bod_src | wd_pulse;

  // Ports are released only by logic; the hold itself needs no clock edge
  assign port_hold = power_low | (~ext_reset_n & reset_pin_enable) |
                     (brownout_low & bod_enabled) | internal_reset;

  // Delay length from the start-up and clock select fuses
  wire [15:0] delay_load = (DELAY_BASE_TICKS << startup_time_fuses) +
                           {12'h000, clock_select_fuses};
  reg  [15:0] delay_cnt;

  // Internal reset: held while any source is active, then stretched
  always @(posedge clock) begin
    if (rst) begin
      internal_reset <= 1'b1;
      delay_cnt      <= DELAY_BASE_TICKS;
    end else if (any_src) begin
      internal_reset <= 1'b1;
      delay_cnt      <= delay_load;
    end else if (delay_cnt != 16'h0000) begin
      if (tick) begin
        delay_cnt <= delay_cnt - 16'h0001;
      end
    end else begin
      internal_reset <= 1'b0;
    end
  end

  // APB decode; writes land in the access phase only
  wire acc       = psel & penable;
  wire mapped    = (paddr == `OFF_CAUSE) | (paddr == `OFF_WDCTRL) |
                   (paddr == `OFF_CMP) | (paddr == `OFF_RESTART);
  wire wr        = acc & pwrite & mapped;
  wire wr_cause  = wr & (paddr == `OFF_CAUSE);
  wire wr_ctrl   = wr & (paddr == `OFF_WDCTRL) & ~internal_reset;
  wire wr_cmp    = wr & (paddr == `OFF_CMP) & ~internal_reset;
  wire wr_rstrt  = wr & (paddr == `OFF_RESTART);

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Watchdog control state
  reg        wd_flag;
  reg        wd_ie;
  reg        wd_en;
  reg  [3:0] wd_p;
  reg  [2:0] ce_cnt;
  reg  [3:0] cause;
  reg        comparator_bandgap_select;
  reg [19:0] wd_cnt;

  wire level2  = safety_level_fuse;
  wire ce_open = (ce_cnt != 3'h0);
  wire wde_eff = level2 | wd_en | cause[`CAUSE_WATCHDOG_RESET_FLAG];
  wire running = wde_eff | wd_ie;

  // Reserved period codes are held at the longest period
  wire [3:0]  p_eff  = (wd_p > `WDP_MAX) ? `WDP_MAX : wd_p;
  wire [20:0] lim    = `WDT_BASE_CYCLES << p_eff;
  wire [19:0] lim_m1 = lim[19:0] - 20'h0_0001;

  wire timeout     = tick & running & ~internal_reset & (wd_cnt == lim_m1);
  wire timeout_irq = timeout & wd_ie;
  wire timeout_rst = timeout & ~wd_ie & wde_eff;

  // Watchdog counter
  always @(posedge clock) begin
    if (rst || internal_reset || !running || wr_rstrt) begin
      wd_cnt <= 20'h0_0000;
    end else if (tick) begin
      if (wd_cnt == lim_m1) begin
        wd_cnt <= 20'h0_0000;
      end else begin
        wd_cnt <= wd_cnt + 20'h0_0001;
      end
    end
  end

  // One-cycle reset pulse; delay counting begins once it drops
  always @(posedge clock) begin
    if (rst) begin
      wd_pulse <= 1'b0;
    end else begin
      wd_pulse <= timeout_rst;
    end
  end

  // Next values for the control register
  reg       next_flag;
  reg       next_ie;
  reg       next_en;
  reg [3:0] next_p;
  reg [2:0] next_ce;
  wire [3:0] wr_p  = {pwdata[`WD_P3], pwdata[2:0]};
  wire       w_ce  = pwdata[`WD_CE];
  wire       w_en  = pwdata[`WD_EN];

  always @* begin
    next_flag = wd_flag;
    next_ie   = wd_ie;
    next_en   = wd_en;
    next_p    = wd_p;
    next_ce   = ce_open ? ce_cnt - 3'h1 : 3'h0;
    if (wr_ctrl) begin
      next_ie = pwdata[`WD_IE];
      if (pwdata[`WD_FLAG]) begin
        next_flag = 1'b0;
      end
      if (w_ce && w_en) begin
        next_ce = `CE_WINDOW;
      end
      if (!level2) begin
        next_p = wr_p;
        if (w_en) begin
          next_en = 1'b1;
        end else if (ce_open && !w_ce) begin
          next_en = 1'b0;
        end
      end else if (ce_open && !w_ce) begin
        next_p = wr_p;
      end
    end
    if (irq_ack) begin
      next_flag = 1'b0;
    end
    if (timeout_irq) begin
      next_flag = 1'b1;
      if (wde_eff) begin
        next_ie = 1'b0; // Next expiry then resets
      end
    end
  end

  // Control register: back to initial values while reset is held
  always @(posedge clock) begin
    if (rst || internal_reset) begin
      wd_flag <= 1'b0;
      wd_ie   <= 1'b0;
      wd_en   <= 1'b0;
      wd_p    <= 4'h0;
      ce_cnt  <= 3'h0;
    end else begin
      wd_flag <= next_flag;
      wd_ie   <= next_ie;
      wd_en   <= next_en;
      wd_p    <= next_p;
      ce_cnt  <= next_ce;
    end
  end

  // Cause flags: power-on clears the rest; an event beats a software clear
  reg [3:0] next_cause;

  always @* begin
    next_cause = wr_cause ? (cause & pwdata[3:0]) : cause;
    if (ext_src) begin
      next_cause[`CAUSE_EXTRF] = 1'b1;
    end
    if (bod_src) begin
      next_cause[`CAUSE_BORF] = 1'b1;
    end
    if (wd_pulse) begin
      next_cause[`CAUSE_WATCHDOG_RESET_FLAG] = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      cause <= `CAUSE_POR_VALUE;
    end else if (por_src) begin
      cause <= `CAUSE_POR_VALUE;
    end else begin
      cause <= next_cause;
    end
  end

  // Comparator bandgap select and the reference enable
  always @(posedge clock) begin
    if (rst || internal_reset) begin
      comparator_bandgap_select       <= 1'b0;
      ref_enable <= bod_enabled & ~rst;
    end else begin
      if (wr_cmp) begin
        comparator_bandgap_select <= pwdata[`CMP_BANDGAP];
      end
      ref_enable <= bod_enabled | comparator_bandgap_select;
    end
  end

  assign wdt_irq = wd_flag;

  // Read data is captured in the setup phase so the access needs no wait
  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `OFF_CAUSE: begin
          prdata[3:0] <= cause;
        end
        `OFF_WDCTRL: begin
          prdata[7:0] <= {wd_flag, wd_ie, wd_p[3], ce_open, wde_eff, wd_p[2:0]};
        end
        `OFF_CMP: begin
          prdata[`CMP_BANDGAP] <= comparator_bandgap_select;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

/* File: rtl/reset_watchdog_defs.vh */
// Summary of operation
// - Any active reset returns every control register except the cause flags to its initial value.
// - Port hold asserts straight from raw reset sources, no clock needed.
// - Internal reset is stretched by a delay chosen by start-up and clock fuses.
// - Exactly four causes feed reset: power-on, pin, watchdog, brown-out.
// - Enabled reset pin held low long enough resets the device.
// - Reset pin rising starts the delay count before release.
// - Power-on detector asserts reset at once; release starts the delay count.
// - Enabled brown-out asserts reset at once; recovery waits the delay count.
// - Watchdog reset is a one-cycle pulse; the delay starts after it falls.
// - Watchdog counts ticks of a 128 kHz time base.
// - Watchdog counter clears on restart, when disabled, and on chip reset.
// - Ten watchdog periods are selectable by the timeout select bits.
// - Expiry without restart resets the device.
// - Watchdog may raise a wake-capable interrupt instead of a reset.
// - Safety fuse picks level 1 or level 2 protection.
// - Level 1 accepts setting the enable bit at any time.
// - Level 2 keeps the watchdog enabled and enable reads as one.
// - Level 2 period change needs the window; written enable value is ignored.
// - Reference enable is on only for brown-out enabled or bandgap select.
// - Change window enable clears itself four cycles after being set.
// - Enable and interrupt enable decode to stop, interrupt, reset, interrupt then reset.
// - Codes 0 to 9 give 2K doubling to 1024K cycles; others reserved.
// - Level 1 forces the enable bit while the watchdog reset flag is set.
`ifndef RESET_WATCHDOG_DEFS_VH
`define RESET_WATCHDOG_DEFS_VH

`define SYS_CLK_HZ        125000000
`define WDT_OSC_HZ        128000
`define DELAY_BASE_TICKS  16'h0040

`define OFF_CAUSE         8'h00
`define OFF_WDCTRL        8'h04
`define OFF_CMP           8'h08
`define OFF_RESTART       8'h0C

`define CAUSE_PORF        0
`define CAUSE_EXTRF       1
`define CAUSE_BORF        2
`define CAUSE_WATCHDOG_RESET_FLAG        3
`define CAUSE_POR_VALUE   4'h1

`define WD_FLAG           7
`define WD_IE             6
`define WD_P3             5
`define WD_CE             4
`define WD_EN             3

`define CMP_BANDGAP       6

`define CE_WINDOW         3'h4
`define WDT_BASE_CYCLES   21'h0_0800
`define WDP_MAX           4'h9
`define BOD_OFF_CODE      3'h7

`endif

/* File: test/reset_watchdog_props.sv */
`timescale 1ns/10ps
module reset_watchdog_props #(
  parameter        TICK_DIV         = 4,
  parameter [15:0] DELAY_BASE_TICKS = 16'h0002
) (
  input wire        clock,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        power_low,
  input wire        ext_reset_n,
  input wire        reset_pin_enable,
  input wire        brownout_low,
  input wire [2:0]  brownout_level_fuses,
  input wire        safety_level_fuse,
  input wire        internal_reset,
  input wire        port_hold,
  input wire        wdt_irq,
  input wire        ref_enable
);
  // Source decode seen from the raw pins
  wire pin_low = !ext_reset_n && reset_pin_enable;
  wire bod_on  = brownout_level_fuses != 3'h7;
  wire bod_low = brownout_low && bod_on;
  wire quiet   = !power_low && !pin_low && !bod_low;
  wire rd      = psel && penable && !pwrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_hold_power: assert property (power_low |-> port_hold)
    else $error("port hold missing on power low");
  a_hold_pin: assert property (pin_low |-> port_hold)
    else $error("port hold missing on reset pin");
  a_power_reset: assert property (power_low [*4] |-> internal_reset)
    else $error("power low did not reset");
  a_pin_reset: assert property (pin_low [*4] |-> internal_reset)
    else $error("reset pin did not reset");
  a_bod_reset: assert property (bod_low [*4] |-> internal_reset)
    else $error("brown-out did not reset");
  a_release_late: assert property ($fell(internal_reset) |-> $past(quiet, 4))
    else $error("reset released without delay");
  a_ref_bod: assert property (bod_on |=> ref_enable)
    else $error("reference off with brown-out on");
  a_lvl2_enable: assert property (rd && paddr == 8'h04 && safety_level_fuse |-> prdata[3])
    else $error("enable bit read zero at level 2");
  a_cmp_held: assert property (rd && paddr == 8'h08 && $past(internal_reset, 2) |-> prdata == 0)
    else $error("comparator register not held in reset");
  c_irq: cover property ($rose(wdt_irq));
  c_release: cover property ($fell(internal_reset));
  c_ctrl_read: cover property (rd && paddr == 8'h04);
endmodule
bind reset_and_watchdog_control reset_watchdog_props #(.TICK_DIV(TICK_DIV),
  .DELAY_BASE_TICKS(DELAY_BASE_TICKS)) u_props (.clock, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .power_low, .ext_reset_n, .reset_pin_enable, .brownout_low,
  .brownout_level_fuses, .safety_level_fuse, .internal_reset, .port_hold, .wdt_irq,
  .ref_enable);

/* File: test/tb_reset_and_watchdog_control.sv */
`timescale 1ns/10ps
module tb_reset_and_watchdog_control;
  reg         clock, rst, psel, penable, pwrite, power_low, ext_reset_n, irq_ack;
  reg         reset_pin_enable, brownout_low, safety_level_fuse, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [2:0]  brownout_level_fuses;
  reg  [1:0]  startup_time_fuses;
  reg  [3:0]  clock_select_fuses;
  wire [31:0] prdata;
  wire        pready, pslverr, internal_reset, port_hold, wdt_irq, ref_enable;
  integer     error_cnt, n_checks, seed, i, n, c;

  // Short tick and delay keep watchdog periods inside the run budget
  reset_and_watchdog_control #(.TICK_DIV(4), .DELAY_BASE_TICKS(16'h0002)) u_reset_and_watchdog_control (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_low(power_low), .ext_reset_n(ext_reset_n), .reset_pin_enable(reset_pin_enable),
    .brownout_low(brownout_low), .brownout_level_fuses(brownout_level_fuses),
    .safety_level_fuse(safety_level_fuse), .startup_time_fuses(startup_time_fuses),
    .clock_select_fuses(clock_select_fuses), .irq_ack(irq_ack),
    .internal_reset(internal_reset), .port_hold(port_hold), .wdt_irq(wdt_irq),
    .ref_enable(ref_enable));

  // Free-running system clock
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clock);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      k = 0;
      @(posedge clock);
      while (pready !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge clock);
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask

  // Reads wait out any open change window first
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      repeat (5) @(posedge clock);
      apb(0, a, 0);
      chk(rd, exp);
    end
  endtask

  // Bounded wait: sel picks the interrupt line, else internal reset
  task wait_until(input sel, input lvl, output integer cnt);
    begin
      cnt = 0;
      while ((sel ? wdt_irq : internal_reset) !== lvl && cnt < 20000) begin
        @(posedge clock);
        cnt = cnt + 1;
      end
      if (cnt >= 20000) error_cnt = error_cnt + 1; // A lost event counts as a mismatch
    end
  endtask

  task end_of_test;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt = error_cnt + 1;
    end_of_test;
  end

  initial begin
    error_cnt = 0;
    n_checks = 0;
    seed = 86428;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, irq_ack} = 44'h000_0000_0000;
    {power_low, brownout_low, safety_level_fuse} = 3'h0;
    {ext_reset_n, reset_pin_enable, brownout_level_fuses} = 5'h1f;
    {startup_time_fuses, clock_select_fuses} = 6'h00;
    repeat (5) @(posedge clock);
    rst <= 0;
    wait_until(0, 0, c);
    rchk(8'h00, 1);
    rchk(8'h04, 0);
    apb(1, 8'h00, 0);
    apb(1, 8'h04, 8'h08);
    rchk(8'h04, 8'h08);
    apb(1, 8'h04, 0);
    rchk(8'h04, 8'h08);
    apb(1, 8'h04, 8'h18);
    repeat (5) @(posedge clock);
    apb(1, 8'h04, 0);
    rchk(8'h04, 8'h08);
    apb(1, 8'h04, 8'h18);
    apb(1, 8'h04, 0);
    rchk(8'h04, 0);
    for (i = 0; i < 12; i = i + 1) begin
      n = $random(seed) & 32'h0000_00ff;
      n = (i < 2) ? i * 9 : n % 10;
      apb(1, 8'h04, {n[3], 2'b00, n[2:0]});
      rchk(8'h04, {n[3], 2'b00, n[2:0]});
    end
    apb(0, 8'h10, 0);
    chk(err, 1);
    apb(1, 8'h04, 8'h40);
    wait_until(1, 1, c);
    chk(c >= 8188 && c <= 8204, 1);
    chk(internal_reset, 0);
    irq_ack <= 1;
    @(posedge clock);
    irq_ack <= 0;
    repeat (2) @(posedge clock);
    chk(wdt_irq, 0);
    apb(1, 8'h04, 8'h08);
    repeat (6000) @(posedge clock);
    apb(1, 8'h0c, 0);
    wait_until(0, 1, c);
    chk(c >= 8188 && c <= 8210, 1);
    wait_until(0, 0, c);
    rchk(8'h00, 8);
    rchk(8'h04, 8);
    apb(1, 8'h00, 0);
    apb(1, 8'h04, 8'h18);
    apb(1, 8'h04, 0);
    rchk(8'h04, 0);
    chk(ref_enable, 0);
    apb(1, 8'h08, 32'h0000_0040);
    repeat (2) @(posedge clock);
    chk(ref_enable, 1);
    for (i = 0; i < 3; i = i + 1) begin
      n = $random(seed);
      startup_time_fuses <= n[1:0];
      clock_select_fuses <= n[5:2];
      brownout_level_fuses <= (i == 2) ? 3'h4 : 3'h7;
      @(posedge clock);
      power_low <= (i == 0);
      ext_reset_n <= (i != 1);
      brownout_low <= (i == 2);
      repeat (6) @(posedge clock);
      apb(0, 8'h08, 0);
      chk(rd, 0);
      power_low <= 0;
      ext_reset_n <= 1;
      brownout_low <= 0;
      n = ((2 << startup_time_fuses) + clock_select_fuses) * 4;
      wait_until(0, 0, c);
      chk(c >= n - 4 && c <= n + 8, 1);
      rchk(8'h00, 1 << i);
      apb(1, 8'h00, 0);
    end
    safety_level_fuse <= 1;
    rst <= 1;
    repeat (5) @(posedge clock);
    rst <= 0;
    wait_until(0, 0, c);
    rchk(8'h04, 8'h08);
    apb(1, 8'h04, 8'h03);
    rchk(8'h04, 8'h08);
    apb(1, 8'h04, 8'h18);
    apb(1, 8'h04, 8'h03);
    rchk(8'h04, 8'h0b);
    apb(1, 8'h04, 8'h18);
    apb(1, 8'h04, 0);
    rchk(8'h04, 8'h08);
    end_of_test;
  end
endmodule
